// *** hdl/dac_clk_pkg.sv ***
// constants, register map and decoding shared by the clock control block
package dac_clk_pkg;
  // register byte offsets
  localparam logic [7:0]  OFF_CTRL      = 8'h00;
  localparam logic [7:0]  OFF_STATUS    = 8'h04;
  localparam logic [7:0]  OFF_IRQ_STAT  = 8'h08;
  localparam logic [7:0]  OFF_IRQ_MASK  = 8'h0C;
  localparam logic [7:0]  OFF_CAPTURE   = 8'h10;
  // control fields
  localparam int          CTRL_SYNC_BIT = 0;
  localparam int          CTRL_CAPT_BIT = 1;
  localparam logic        CTRL_CAPT_RST = 1'h1;
  // status fields
  localparam int          ST_LOCK_BIT   = 0;
  localparam int          ST_MULT_BIT   = 1;
  localparam int          ST_ZS_BIT     = 2;
  localparam int          ST_CLK1X_BIT  = 3;
  localparam int          ST_RATIO_LSB  = 4;
  localparam int          ST_RATE_LSB   = 8;
  // interrupt fields
  localparam int          IRQ_W         = 3;
  localparam int          IRQ_LOCK_BIT  = 0;
  localparam int          IRQ_LOSS_BIT  = 1;
  localparam int          IRQ_SYNC_BIT  = 2;
  localparam logic [2:0]  IRQ_MASK_RST  = 3'h0;
  // datapath
  localparam logic [13:0] MIDSCALE      = 14'h2000;
  localparam logic [13:0] CODE_RST      = 14'h2000;
  // timing counts in clock cycles and the lfsr seed
  localparam logic [7:0]  RATE_WIN      = 8'hFF;
  localparam logic [7:0]  REF_TIMEOUT   = 8'hFF;
  localparam logic [23:0] ACQ_BASE      = 24'h000100;
  localparam logic [7:0]  LFSR_SEED     = 8'hA5;
  // bus responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // strap code to prescaler divide ratio
  function automatic logic [3:0] ratio_value(input logic [1:0] code);
    unique case (code)
      2'h0: ratio_value = 4'h1;
      2'h1: ratio_value = 4'h2;
      2'h2: ratio_value = 4'h4;
      default: ratio_value = 4'h8;
    endcase
  endfunction
endpackage

// *** hdl/dac_clock_multiplier_control.sv ***
// clock generation, lock signalling and data capture for the dac core
`timescale 1ns/1ps
module dac_clock_multiplier_control
  import dac_clk_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // straps and pins
  input  wire logic        mult_enable_i,
  input  wire logic        zero_stuff_select_i,
  input  wire logic        filter_response_select_i,
  input  wire logic        prescale_code_hi_i,
  input  wire logic        prescale_code_lo_i,
  input  wire logic        sync_reset_i,
  input  wire logic        ref_clk_i,
  output logic             lock_indicator_out_o,
  // input data path
  input  wire logic [13:0] data_i,
  output logic [13:0] data_latch_o,
  output logic             capture_o,
  // interpolation filter side
  input  wire logic [13:0] filt_data_i,
  input  wire logic        filt_valid_i,
  output logic             filt_highpass_o,
  output logic [13:0] dac_code_o,
  output logic             dac_update_o,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // interrupt
  output logic             irq_o
);
  logic        ref_q_reg, ref_rise, zs, sync_pulse;
  logic [1:0]  ratio_code;
  logic [1:0]  ph_reg, ph_next, ph_adv;
  logic        clk1x_reg, clk1x_next, sync_q_reg, sync_q_next, held_reg, held_next;
  logic [7:0]  per_cnt_reg, per_cnt_next, per_reg, per_next, interval;
  logic [7:0]  tick_cnt_reg, tick_cnt_next, win_reg, win_next;
  logic [7:0]  edges_reg, edges_next, rate_reg, rate_next;
  logic        tick, slot_reg, slot_next, capt_now;
  logic [13:0] hold_reg, hold_next, latch_next, code_next;
  logic        locked, wander, locked_q_reg;
  logic        ctrl_capt_reg, ctrl_capt_next;
  logic [2:0]  irq_stat_reg, irq_stat_next, irq_mask_reg, irq_mask_next, irq_ev;
  logic [7:0]  aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next, rdata_next;
  logic [3:0]  w_strb_reg, w_strb_next;
  logic        aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic        bvalid_next, rvalid_next, do_write, do_read, sw_sync;
  logic [1:0]  bresp_next, rresp_next;

  assign zs         = zero_stuff_select_i;
  assign ratio_code = {prescale_code_hi_i, prescale_code_lo_i};
  assign ref_rise   = ref_clk_i && !ref_q_reg;
  assign sync_pulse = sync_reset_i || sw_sync;

  lock_tracker u_lock (
    .mclk_i       (mclk_i),
    .rst_n_i      (rst_n_i),
    .enable_i     (mult_enable_i),
    .ref_rise_i   (ref_rise),
    .ratio_code_i (ratio_code),
    .rate_est_i   (rate_reg),
    .locked_o     (locked),
    .wander_o     (wander)
  );

  // bypass divider, rate measure and update ticks
  always_comb begin
    ph_adv       = (ph_reg == (zs ? 2'h3 : 2'h1)) ? 2'h0 : ph_reg + 2'h1;
    ph_next      = ph_reg;
    clk1x_next   = clk1x_reg;
    held_next    = held_reg;
    sync_q_next  = sync_pulse;
    capt_now     = 1'b0;
    if (mult_enable_i) begin
      // loop mode keeps phase with every reference edge
      ph_next    = 2'h0;
      clk1x_next = 1'b1;
      held_next  = 1'b0;
      capt_now   = ref_rise;
    end else if (sync_pulse) begin
      // reset holds 1x high and the divider at its start
      ph_next    = 2'h0;
      clk1x_next = 1'b1;
      held_next  = 1'b1;
    end else if (ref_rise) begin
      ph_next    = ph_adv;
      clk1x_next = (ph_adv == 2'h0);
      capt_now   = (ph_adv == 2'h0);
      held_next  = 1'b0;
    end
    per_cnt_next  = ref_rise ? 8'h01 : (per_cnt_reg == 8'hFF ? per_cnt_reg : per_cnt_reg + 8'h01);
    per_next      = ref_rise ? per_cnt_reg : per_reg;
    interval      = zs ? (per_reg >> 2) : (per_reg >> 1);
    if (interval == 8'h00) begin
      interval = 8'h01;
    end
    // bypass updates on every reference edge, loop mode at 2x or 4x
    if (!mult_enable_i) begin
      tick          = ref_rise;
      tick_cnt_next = 8'h00;
    end else if (ref_rise) begin
      tick          = 1'b1;
      tick_cnt_next = interval - 8'h01;
    end else if (tick_cnt_reg == 8'h00) begin
      tick          = 1'b1;
      tick_cnt_next = interval - 8'h01;
    end else begin
      tick          = 1'b0;
      tick_cnt_next = tick_cnt_reg - 8'h01;
    end
    win_next   = (win_reg == RATE_WIN) ? 8'h00 : win_reg + 8'h01;
    edges_next = (win_reg == RATE_WIN) ? 8'h00 :
                 (ref_rise && edges_reg != 8'hFF) ? edges_reg + 8'h01 : edges_reg;
    rate_next  = (win_reg == RATE_WIN) ? edges_reg : rate_reg;
  end

  // capture and zero-stuffing datapath
  always_comb begin
    hold_next  = filt_valid_i ? filt_data_i : hold_reg;
    latch_next = (capt_now && ctrl_capt_reg) ? data_i : data_latch_o;
    slot_next  = slot_reg;
    code_next  = dac_code_o;
    if (tick) begin
      if (zs && slot_reg) begin
        code_next = MIDSCALE;
      end else begin
        code_next = hold_reg;
      end
      slot_next = zs ? !slot_reg : 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_q_reg    <= 1'b0;
      ph_reg       <= 2'h0;
      clk1x_reg    <= 1'b1;
      held_reg     <= 1'b0;
      sync_q_reg   <= 1'b0;
      per_cnt_reg  <= 8'h00;
      per_reg      <= 8'h02;
      tick_cnt_reg <= 8'h00;
      win_reg      <= 8'h00;
      edges_reg    <= 8'h00;
      rate_reg     <= 8'h00;
      hold_reg     <= CODE_RST;
      data_latch_o <= CODE_RST;
      slot_reg     <= 1'b0;
      dac_code_o   <= CODE_RST;
      dac_update_o <= 1'b0;
      capture_o    <= 1'b0;
      locked_q_reg <= 1'b0;
    end else begin
      ref_q_reg    <= ref_clk_i;
      ph_reg       <= ph_next;
      clk1x_reg    <= clk1x_next;
      held_reg     <= held_next;
      sync_q_reg   <= sync_q_next;
      per_cnt_reg  <= per_cnt_next;
      per_reg      <= per_next;
      tick_cnt_reg <= tick_cnt_next;
      win_reg      <= win_next;
      edges_reg    <= edges_next;
      rate_reg     <= rate_next;
      hold_reg     <= hold_next;
      data_latch_o <= latch_next;
      slot_reg     <= slot_next;
      dac_code_o   <= code_next;
      dac_update_o <= tick;
      capture_o    <= capt_now && ctrl_capt_reg;
      locked_q_reg <= locked;
    end
  end

  // lock output: steady high, wandering, or the 1x clock
  assign lock_indicator_out_o = !mult_enable_i ? clk1x_reg : (locked ? 1'b1 : wander);
  assign filt_highpass_o      = filter_response_select_i;

  // register slave
  assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign do_read       = s_axi_arvalid && s_axi_arready;
  assign sw_sync       = do_write && aw_addr_reg == OFF_CTRL && w_strb_reg[0] &&
                         w_data_reg[CTRL_SYNC_BIT];

  always_comb begin
    aw_full_next   = aw_full_reg;
    aw_addr_next   = aw_addr_reg;
    w_full_next    = w_full_reg;
    w_data_next    = w_data_reg;
    w_strb_next    = w_strb_reg;
    bvalid_next    = s_axi_bvalid && !s_axi_bready;
    bresp_next     = s_axi_bresp;
    rvalid_next    = s_axi_rvalid && !s_axi_rready;
    rresp_next     = s_axi_rresp;
    rdata_next     = s_axi_rdata;
    ctrl_capt_next = ctrl_capt_reg;
    irq_mask_next  = irq_mask_reg;
    irq_ev         = '0;
    irq_ev[IRQ_LOCK_BIT] = locked && !locked_q_reg;
    irq_ev[IRQ_LOSS_BIT] = !locked && locked_q_reg;
    irq_ev[IRQ_SYNC_BIT] = !sync_pulse && sync_q_reg && !mult_enable_i;
    irq_stat_next  = irq_stat_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_full_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_full_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (do_write) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = RESP_OKAY;
      unique case (aw_addr_reg)
        OFF_CTRL: begin
          if (w_strb_reg[0]) begin
            ctrl_capt_next = w_data_reg[CTRL_CAPT_BIT];
          end
        end
        OFF_IRQ_MASK: begin
          if (w_strb_reg[0]) begin
            irq_mask_next = w_data_reg[IRQ_W-1:0];
          end
        end
        OFF_STATUS, OFF_IRQ_STAT, OFF_CAPTURE: bresp_next = RESP_OKAY;
        default: bresp_next = RESP_SLVERR;
      endcase
    end
    if (do_read) begin
      rvalid_next = 1'b1;
      rresp_next  = RESP_OKAY;
      rdata_next  = 32'h00000000;
      unique case (s_axi_araddr)
        OFF_CTRL:     rdata_next[CTRL_CAPT_BIT] = ctrl_capt_reg;
        OFF_STATUS: begin
          rdata_next[ST_LOCK_BIT]  = locked;
          rdata_next[ST_MULT_BIT]  = mult_enable_i;
          rdata_next[ST_ZS_BIT]    = zs;
          rdata_next[ST_CLK1X_BIT] = clk1x_reg;
          rdata_next[ST_RATIO_LSB +: 4] = ratio_value(ratio_code);
          rdata_next[ST_RATE_LSB +: 8]  = rate_reg;
        end
        OFF_IRQ_STAT: begin
          rdata_next[IRQ_W-1:0] = irq_stat_reg;
          irq_stat_next = '0;
        end
        OFF_IRQ_MASK: rdata_next[IRQ_W-1:0] = irq_mask_reg;
        OFF_CAPTURE:  rdata_next[13:0] = data_latch_o;
        default:      rresp_next = RESP_SLVERR;
      endcase
    end
    // a new event wins over the read clear
    irq_stat_next = irq_stat_next | irq_ev;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_full_reg   <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_full_reg    <= 1'b0;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
      ctrl_capt_reg <= CTRL_CAPT_RST;
      irq_mask_reg  <= IRQ_MASK_RST;
      irq_stat_reg  <= '0;
    end else begin
      aw_full_reg   <= aw_full_next;
      aw_addr_reg   <= aw_addr_next;
      w_full_reg    <= w_full_next;
      w_data_reg    <= w_data_next;
      w_strb_reg    <= w_strb_next;
      s_axi_bvalid  <= bvalid_next;
      s_axi_bresp   <= bresp_next;
      s_axi_rvalid  <= rvalid_next;
      s_axi_rresp   <= rresp_next;
      s_axi_rdata   <= rdata_next;
      ctrl_capt_reg <= ctrl_capt_next;
      irq_mask_reg  <= irq_mask_next;
      irq_stat_reg  <= irq_stat_next;
    end
  end

  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  a_lock_high_when_locked: assert property (mult_enable_i && locked |-> lock_indicator_out_o)
    else $error("lock output low while locked");
  a_bypass_1x_steps: assert property (!mult_enable_i && !$past(mult_enable_i)
    && $changed(lock_indicator_out_o) |-> $past(ref_rise) || $past(sync_pulse))
    else $error("bypass 1x clock moved without a reference edge");
  a_reset_forces_high: assert property (!mult_enable_i && sync_pulse |=> clk1x_reg)
    else $error("1x clock not high after reset");
  a_release_first_low: assert property (!mult_enable_i && held_reg && !sync_pulse
    && ref_rise |=> !clk1x_reg)
    else $error("1x clock not low on first edge after reset");
  a_capture_on_1x_rise: assert property (!mult_enable_i && capture_o |-> $rose(clk1x_reg))
    else $error("bypass capture not aligned to 1x rise");
  a_bypass_every_second: assert property (!mult_enable_i && !zs && !sync_pulse
    && ref_rise && $past(ref_rise) == 1'b0 && ph_reg == 2'h1 |=> clk1x_reg)
    else $error("bypass capture phase wrong");
  a_zs_midscale: assert property (tick && zs && slot_reg |=> dac_code_o == MIDSCALE)
    else $error("midscale not inserted");
  a_ratio_status: assert property (do_read && s_axi_araddr == OFF_STATUS
    |=> s_axi_rdata[ST_RATIO_LSB +: 4] == (4'h1 << $past(ratio_code)))
    else $error("divide ratio decode wrong");
  a_update_rate: assert property (!mult_enable_i && ref_rise |=> dac_update_o)
    else $error("update missing on reference edge");
  a_irq_sticky: assert property (!(do_read && s_axi_araddr == OFF_IRQ_STAT)
    |=> (irq_stat_reg & $past(irq_stat_reg)) == $past(irq_stat_reg))
    else $error("status bit dropped without a read");
  a_irq_set_wins: assert property (|irq_ev |=> (irq_stat_reg & $past(irq_ev)) == $past(irq_ev))
    else $error("event lost against the read clear");

  c_lock_reached: cover property (mult_enable_i ##1 locked);
  c_bypass_capture: cover property (!mult_enable_i && capture_o);
  c_zs_stuff: cover property (tick && zs && slot_reg);
  c_irq_raised: cover property ($rose(irq_o));
endmodule

// *** hdl/lock_tracker.sv ***
// loop acquisition model and lock indicator source
`timescale 1ns/1ps
module lock_tracker
  import dac_clk_pkg::*;
(
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  // loop inputs
  input  wire logic       enable_i,
  input  wire logic       ref_rise_i,
  input  wire logic [1:0] ratio_code_i,
  input  wire logic [7:0] rate_est_i,
  // loop outputs
  output logic            locked_o,
  output logic            wander_o
);
  typedef enum logic [2:0] {
    S_OFF  = 3'b001,
    S_ACQ  = 3'b010,
    S_LOCK = 3'b100
  } lock_state_e;

  lock_state_e state_reg, state_next;
  logic [23:0] acq_reg, acq_next, target;
  logic [7:0]  idle_reg, idle_next, lfsr_reg, lfsr_next;
  logic [1:0]  code_reg, code_next;
  logic [3:0]  ratio;
  logic        lost;

  always_comb begin
    ratio      = ratio_value(ratio_code_i);
    // longer at higher rate and at larger ratio
    target     = (ACQ_BASE + {8'h00, rate_est_i, 8'h00}) * {20'h00000, ratio};
    idle_next  = ref_rise_i ? 8'h00 : (idle_reg == REF_TIMEOUT ? idle_reg : idle_reg + 8'h01);
    lost       = (idle_reg == REF_TIMEOUT) || (ratio_code_i != code_reg);
    code_next  = ratio_code_i;
    lfsr_next  = {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
    state_next = state_reg;
    acq_next   = acq_reg;
    unique case (state_reg)
      S_OFF: begin
        acq_next = 24'h000000;
        if (enable_i) begin
          state_next = S_ACQ;
        end
      end
      S_ACQ: begin
        acq_next = lost ? 24'h000000 : acq_reg + 24'h000001;
        if (!enable_i) begin
          state_next = S_OFF;
        end else if (acq_reg >= target) begin
          state_next = S_LOCK;
        end
      end
      S_LOCK: begin
        acq_next = 24'h000000;
        if (!enable_i) begin
          state_next = S_OFF;
        end else if (lost) begin
          state_next = S_ACQ;
        end
      end
      default: begin
        state_next = S_OFF;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= S_OFF;
      acq_reg   <= 24'h000000;
      idle_reg  <= 8'h00;
      lfsr_reg  <= LFSR_SEED;
      code_reg  <= 2'h0;
    end else begin
      state_reg <= state_next;
      acq_reg   <= acq_next;
      idle_reg  <= idle_next;
      lfsr_reg  <= lfsr_next;
      code_reg  <= code_next;
    end
  end

  assign locked_o = (state_reg == S_LOCK);
  // irregular toggling while acquiring
  assign wander_o = lfsr_reg[0];
endmodule

// *** verif/dac_clock_multiplier_control_tb_top.sv ***
// self-checking bench for the dac clock control block
`timescale 1ns/1ps
module dac_clock_multiplier_control_tb_top;
  import dac_clk_pkg::*;
  logic mclk_i = 0, rst_n_i = 0, mult_enable_i = 0, zero_stuff_select_i = 0;
  logic filter_response_select_i = 0, prescale_code_hi_i = 0, prescale_code_lo_i = 0;
  logic sync_reset_i = 0, run = 0, filt_valid_i = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, prev = 0;
  logic ref_clk_i, lock_indicator_out_o, capture_o, filt_highpass_o, dac_update_o, irq_o;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [13:0] data_i, data_latch_o, dac_code_o, last1, last2, filt_data_i = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  int          fails = 0, n_checks = 0, cyc = 0, rises = 0, caps = 0, upds = 0, t1, t2;

  dac_clock_multiplier_control i_dac_clock_multiplier_control (.mclk_i, .rst_n_i,
    .mult_enable_i, .zero_stuff_select_i, .filter_response_select_i, .prescale_code_hi_i,
    .prescale_code_lo_i, .sync_reset_i, .ref_clk_i, .lock_indicator_out_o, .data_i,
    .data_latch_o, .capture_o, .filt_data_i, .filt_valid_i, .filt_highpass_o, .dac_code_o,
    .dac_update_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .irq_o);
  data_source_model i_data_source_model (.mclk_i, .rst_n_i, .run_i(run),
    .ref_clk_o(ref_clk_i), .data_o(data_i));

  initial forever #50 mclk_i = ~mclk_i;

  // counts rises, captures and converter ticks as the design should see them
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    prev <= ref_clk_i;
    if (ref_clk_i && !prev) rises <= rises + 1;
    if (capture_o) caps <= caps + 1;
    if (dac_update_o) begin
      upds <= upds + 1;
      last1 <= dac_code_o;
      last2 <= last1;
    end
    if (cyc == 90000) begin
      fails++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string w, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", w, e, s);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge mclk_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        check("bresp", s_axi_bresp, RESP_OKAY);
        break;
      end
    end
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge mclk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge mclk_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic bypass(input logic z);
    int r0, u0, c0, i;
    logic [13:0] smp;
    @(posedge mclk_i);
    zero_stuff_select_i <= z;
    run <= 1'b0;
    sync_reset_i <= 1'b1;
    filt_data_i <= 14'h1234;
    filt_valid_i <= 1'b1;
    @(posedge mclk_i);
    filt_valid_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    check("1x held", lock_indicator_out_o, 1'b1);
    r0 = rises;
    u0 = upds;
    c0 = caps;
    sync_reset_i <= 1'b0;
    run <= 1'b1;
    for (i = 0; i < 400 && caps == c0; i++) @(posedge mclk_i);
    check("rises to capture", rises - r0, z ? 4 : 2);
    smp = data_i;
    check("latched", data_latch_o, smp);
    check("1x at capture", lock_indicator_out_o, 1'b1);
    axr(OFF_CAPTURE);
    check("capture reg", d, {18'h00000, smp});
    for (i = 0; i < 400 && caps < c0 + 3; i++) @(posedge mclk_i);
    check("ticks", upds - u0, z ? 12 : 6);
    if (z) check("stuffed", last1 ^ last2, MIDSCALE ^ 14'h1234);
    $display("bypass test done, zero-stuff %0d", z);
  endtask

  task automatic wait_lock(output int t);
    logic lk;
    int tg;
    tg = 0;
    lk = lock_indicator_out_o;
    for (t = 0; t < 40000 && irq_o !== 1'b1; t++) begin
      @(posedge mclk_i);
      if (lock_indicator_out_o !== lk) tg++;
      lk = lock_indicator_out_o;
    end
    check("toggling", tg > 2, 1'b1);
    check("locked", lock_indicator_out_o, 1'b1);
  endtask

  initial begin
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    check("reset code", dac_code_o, CODE_RST);
    axr(OFF_CTRL);
    check("ctrl", d, 32'h2);
    axr(OFF_IRQ_MASK);
    check("mask", d, 32'h0);
    axr(8'h20);
    check("unmapped", r, RESP_SLVERR);
    axw(OFF_CTRL, 32'h0);
    axr(OFF_CTRL);
    check("capture off", d, 32'h0);
    axw(OFF_CTRL, 32'h2);
    filter_response_select_i <= 1'b1;
    @(posedge mclk_i);
    check("highpass", filt_highpass_o, 1'b1);
    for (int c = 0; c < 4; c++) begin
      {prescale_code_hi_i, prescale_code_lo_i} <= c[1:0];
      axr(OFF_STATUS);
      check("ratio", d[7:4], 4'h1 << c);
    end
    $display("reset and strap test done");
    bypass(1'b0);
    bypass(1'b1);
    {prescale_code_hi_i, prescale_code_lo_i} <= 2'h0;
    zero_stuff_select_i <= 1'b0;
    mult_enable_i <= 1'b1;
    axw(OFF_IRQ_MASK, 32'h1);
    wait_lock(t1);
    axr(OFF_STATUS);
    check("status", d[7:0], 8'h1B);
    check("rate", d[15:8] == 8'h20 || d[15:8] == 8'h1F, 1'b1);
    axr(OFF_IRQ_STAT);
    check("lock event", d, 32'h5);
    check("irq cleared", irq_o, 1'b0);
    prescale_code_lo_i <= 1'b1;
    wait_lock(t2);
    check("longer at ratio 2", t2 > t1, 1'b1);
    axr(OFF_IRQ_STAT);
    check("loss and lock", d, 32'h3);
    $display("multiplier test done");
    complete_run();
  end
endmodule

// *** verif/data_source_model.sv ***
// data source model: reference clock and input samples for the dac
`timescale 1ns/1ps
module data_source_model #(
  parameter int HALF = 4
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // control from bench
  input  wire logic        run_i,
  // reference and samples
  output logic             ref_clk_o,
  output logic [13:0]      data_o
);
  int cnt;
  // reference runs only while a frame is on, otherwise stands low
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_clk_o <= 1'b0;
      cnt       <= 0;
      data_o    <= 14'h0100;
    end else if (!run_i) begin
      ref_clk_o <= 1'b0;
      cnt       <= 0;
    end else if (cnt == HALF - 1) begin
      // bench rate stands for 2x, or 4x with zero-stuffing
      // fixed rate keeps multiplier above its minimum
      cnt       <= 0;
      ref_clk_o <= !ref_clk_o;
      // samples move on the falling edge, clear of the capture edge
      if (ref_clk_o)
        data_o <= data_o + 14'h0001;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
